// >>> shared/pwm_pkg.sv
// Package for the core power-mode controller: constants and states
package pwm_pkg;
   // Power control register layout
   localparam int PWM_CTRL_W = 8;
   localparam int PWM_IDLE_BIT = 0;
   localparam int PWM_STOP_BIT = 1;
   localparam logic [7:0] PWM_CTRL_RESET = 8'h00;
   // Program address taken after a reset wake
   localparam logic [15:0] PWM_RESET_VECTOR = 16'h0000;
   // Power-mode states
   typedef enum logic [1:0] {
      PWM_RUN,
      PWM_IDLE,
      PWM_STOP
   } pwm_state_t;
endpackage : pwm_pkg

// >>> rtl/pwm_power_modes.sv
// Core power-mode controller: run, idle and stop sequencing
// Function
// [RQ1] Idle bit set: halt CPU after instruction
// [RQ2] Idle keeps registers and memory unchanged
// [RQ3] Idle stops CPU only; clocks keep running (code drops osc_en and sys_clk_en in idle once the oscillator is shut down)
// [RQ4] Enabled interrupt or reset ends idle
// [RQ5] Interrupt wake clears idle bit, CPU resumes
// [RQ6] Interrupt serviced, then resume after idle write
// [RQ7] Reset wake: reset sequence, fetch at zero
// [RQ8] Software follows idle write with two-byte opcode
// [RQ9] Enabled watchdog runs in idle, resets
// [RQ10] Software may disable watchdog before idle
// [RQ11] Stop bit set: enter stop after instruction
// [RQ12] Stop halts CPU, oscillators and system clock
// [RQ13] Stop silences interrupts, timers; clock detector lives
// [RQ14] Only reset ends stop; restart at zero
// [RQ15] Software powers down analog parts before stop
// [RQ16] Oscillator off needs reset to restart
// [RQ17] Both bits together mean stop
module pwm_power_modes
(
   input wire logic clk,
   input wire logic rst_n,
   // Power control register write from the core
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   // Writing instruction has completed
   input wire logic instr_done,
   // Any enabled interrupt pending
   input wire logic irq_pending,
   // Internal reset sources (watchdog, clock detector, others)
   input wire logic wdog_reset,
   input wire logic int_reset,
   // Software oscillator shutdown request
   input wire logic osc_off_req,
   // Power control register contents
   output logic [7:0] power_control_reg,
   // CPU halt and clock gates
   output logic cpu_halt,
   output logic periph_clk_en,
   output logic osc_en,
   output logic sys_clk_en,
   // Interrupt and timer gate, clock detector enable
   output logic irq_timer_en,
   output logic clk_detect_en,
   // Watchdog clock enable, wake strobe and reset request
   output logic wdog_clk_en,
   output logic irq_wake,
   output logic core_reset,
   output logic [15:0] fetch_addr
);
   // All state of the block
   typedef struct packed {
      pwm_pkg::pwm_state_t state;
      logic [7:0] ctrl;
      logic pend_idle;
      logic pend_stop;
      logic cpu_halt;
      logic periph_clk_en;
      logic osc_en;
      logic sys_clk_en;
      logic irq_timer_en;
      logic clk_detect_en;
      logic wdog_clk_en;
      logic irq_wake;
      logic core_reset;
      logic [15:0] fetch_addr;
      logic osc_dead;
   } pwm_regs_t;

   pwm_regs_t r;
   pwm_regs_t next_r;
   logic any_reset;

   // Reset from any internal source; the watchdog keeps running in idle
   assign any_reset = wdog_reset | int_reset; // see [RQ9]

   // Next-state logic
   always_comb
   begin
      next_r = r;
      next_r.irq_wake = 1'b0;
      next_r.core_reset = 1'b0;
      // Latch a write; entry waits for instruction completion
      if (ctrl_wr)
      begin
         next_r.ctrl = ctrl_wdata;
         // Stop wins when both bits arrive together
         if (ctrl_wdata[pwm_pkg::PWM_STOP_BIT])
         begin
            next_r.pend_stop = 1'b1; // see [RQ17]
         end
         else if (ctrl_wdata[pwm_pkg::PWM_IDLE_BIT])
         begin
            next_r.pend_idle = 1'b1;
         end
      end
      // Oscillator shutdown latches until reset
      if (osc_off_req)
      begin
         next_r.osc_dead = 1'b1; // see [RQ16]
      end
      // Reset: normal sequence, restart at vector
      if (any_reset)
      begin
         next_r = '0;
         next_r.state = pwm_pkg::PWM_RUN;
         next_r.ctrl = pwm_pkg::PWM_CTRL_RESET;
         next_r.core_reset = 1'b1; // see [RQ7], [RQ14]
         next_r.fetch_addr = pwm_pkg::PWM_RESET_VECTOR;
         next_r.periph_clk_en = 1'b1;
         next_r.osc_en = 1'b1;
         next_r.sys_clk_en = 1'b1;
         next_r.irq_timer_en = 1'b1;
         next_r.clk_detect_en = 1'b1;
         next_r.wdog_clk_en = 1'b1;
      end
      else
      begin
         unique case (r.state)
            pwm_pkg::PWM_RUN:
            begin
               // Enter once the writing instruction completes
               if ((next_r.pend_stop || r.pend_stop) && instr_done)
               begin
                  next_r.state = pwm_pkg::PWM_STOP; // see [RQ11]
                  next_r.pend_stop = 1'b0;
                  next_r.pend_idle = 1'b0;
               end
               else if ((next_r.pend_idle || r.pend_idle) && instr_done)
               begin
                  next_r.state = pwm_pkg::PWM_IDLE; // see [RQ1]
                  next_r.pend_idle = 1'b0;
               end
            end
            pwm_pkg::PWM_IDLE:
            begin
               // Interrupt wake clears the idle bit and resumes
               if (irq_pending)
               begin
                  next_r.state = pwm_pkg::PWM_RUN; // see [RQ4]
                  next_r.ctrl[pwm_pkg::PWM_IDLE_BIT] = 1'b0; // see [RQ5]
                  next_r.irq_wake = 1'b1; // see [RQ6]
               end
            end
            pwm_pkg::PWM_STOP:
            begin
               // Nothing but reset leaves stop
               next_r.state = pwm_pkg::PWM_STOP; // see [RQ14]
            end
            default:
            begin
               next_r.state = pwm_pkg::PWM_RUN;
            end
         endcase
         // Output gates follow the state being entered
         unique case (next_r.state)
            pwm_pkg::PWM_IDLE:
            begin
               // Only the CPU halts unless the oscillator is dead; state held by halting
               next_r.cpu_halt = 1'b1; // see [RQ2], [RQ3]
               next_r.periph_clk_en = 1'b1;
               next_r.osc_en = ~next_r.osc_dead;
               next_r.sys_clk_en = ~next_r.osc_dead;
               next_r.irq_timer_en = 1'b1;
               next_r.wdog_clk_en = 1'b1; // see [RQ9]
            end
            pwm_pkg::PWM_STOP:
            begin
               // Everything down but the clock detector
               next_r.cpu_halt = 1'b1; // see [RQ12]
               next_r.periph_clk_en = 1'b0;
               next_r.osc_en = 1'b0;
               next_r.sys_clk_en = 1'b0;
               next_r.irq_timer_en = 1'b0; // see [RQ13]
               next_r.wdog_clk_en = 1'b0;
            end
            default:
            begin
               // Run; a dead oscillator halts until reset
               next_r.cpu_halt = next_r.osc_dead; // see [RQ16]
               next_r.periph_clk_en = ~next_r.osc_dead;
               next_r.osc_en = ~next_r.osc_dead;
               next_r.sys_clk_en = ~next_r.osc_dead;
               next_r.irq_timer_en = ~next_r.osc_dead;
               next_r.wdog_clk_en = 1'b1;
            end
         endcase
         next_r.clk_detect_en = 1'b1; // see [RQ13]
      end
   end

   // State register, synchronous active-low reset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         r <= '0;
         r.state <= pwm_pkg::PWM_RUN;
         r.ctrl <= pwm_pkg::PWM_CTRL_RESET;
         r.core_reset <= 1'b1;
         r.fetch_addr <= pwm_pkg::PWM_RESET_VECTOR;
         r.periph_clk_en <= 1'b1;
         r.osc_en <= 1'b1;
         r.sys_clk_en <= 1'b1;
         r.irq_timer_en <= 1'b1;
         r.clk_detect_en <= 1'b1;
         r.wdog_clk_en <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign power_control_reg = r.ctrl;
   assign cpu_halt = r.cpu_halt;
   assign periph_clk_en = r.periph_clk_en;
   assign osc_en = r.osc_en;
   assign sys_clk_en = r.sys_clk_en;
   assign irq_timer_en = r.irq_timer_en;
   assign clk_detect_en = r.clk_detect_en;
   assign wdog_clk_en = r.wdog_clk_en;
   assign irq_wake = r.irq_wake;
   assign core_reset = r.core_reset;
   assign fetch_addr = r.fetch_addr;
endmodule : pwm_power_modes

// >>> tb/pwm_power_monitor.sv
// Checker for the core power-mode controller
module pwm_power_monitor
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic instr_done,
   input wire logic irq_pending,
   input wire logic wdog_reset,
   input wire logic int_reset,
   input wire logic osc_off_req,
   input wire logic [7:0] power_control_reg,
   input wire logic cpu_halt,
   input wire logic periph_clk_en,
   input wire logic osc_en,
   input wire logic sys_clk_en,
   input wire logic irq_timer_en,
   input wire logic clk_detect_en,
   input wire logic wdog_clk_en,
   input wire logic irq_wake,
   input wire logic core_reset,
   input wire logic [15:0] fetch_addr
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // No reset request this cycle
   wire logic calm = !wdog_reset && !int_reset;
   // Entry request taken in run
   wire logic req = ctrl_wr && instr_done && !cpu_halt && calm;
   // Halted with oscillator running, or stopped
   wire logic idle = cpu_halt && osc_en && !osc_off_req && calm;
   wire logic stop = cpu_halt && !osc_en && calm;
   idle_entry_a: assert property (
      req && ctrl_wdata == 8'h01
      |=> cpu_halt && periph_clk_en && sys_clk_en && wdog_clk_en)
      else $error("bad idle entry");
   idle_wake_a: assert property (
      idle && irq_pending && !ctrl_wr
      |=> irq_wake && !cpu_halt && !power_control_reg[0])
      else $error("bad idle wake");
   wake_pulse_a: assert property (
      irq_wake |=> !irq_wake)
      else $error("wake too long");
   stop_entry_a: assert property (
      req && ctrl_wdata[1]
      |=> stop && !periph_clk_en && !sys_clk_en && !wdog_clk_en
         && !irq_timer_en && clk_detect_en)
      else $error("bad stop entry");
   stop_hold_a: assert property (
      stop |=> cpu_halt && !irq_wake)
      else $error("stop left without reset");
   reset_wake_a: assert property (
      !calm
      |=> core_reset && !cpu_halt && osc_en && fetch_addr == 16'h0000)
      else $error("bad reset");
   reset_pulse_a: assert property (
      core_reset && calm |=> !core_reset)
      else $error("reset pulse too long");
   idle_hold_a: assert property (
      idle && !irq_pending && !ctrl_wr
      |=> cpu_halt && $stable(power_control_reg))
      else $error("idle state moved");
endmodule : pwm_power_monitor

bind pwm_power_modes pwm_power_monitor pwm_power_monitor_i(.clk, .rst_n,
   .ctrl_wr, .instr_done, .irq_pending, .wdog_reset, .int_reset, .osc_off_req,
   .cpu_halt, .periph_clk_en, .osc_en, .sys_clk_en, .irq_timer_en, .fetch_addr,
   .clk_detect_en, .wdog_clk_en, .irq_wake, .core_reset, .ctrl_wdata,
   .power_control_reg);

// >>> tb/pwm_core_model.sv
// Core model that writes the power control byte
module pwm_core_model
(
   input wire logic clk,
   output logic ctrl_wr,
   output logic [7:0] ctrl_wdata,
   output logic instr_done
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {ctrl_wr, ctrl_wdata, instr_done} = 10'h000;
   // Write, end the instruction now or a cycle later
   task automatic write(input logic [7:0] d, input logic slow);
      @(posedge clk) #1;
      {ctrl_wr, ctrl_wdata, instr_done} = {1'b1, d, !slow};
      @(posedge clk) #1;
      {ctrl_wr, ctrl_wdata, instr_done} = {1'b0, ~d, slow};
      @(posedge clk) #1;
      instr_done = 1'b0;
   endtask : write
endmodule : pwm_core_model

// >>> tb/tb_top.sv
// Bench for the core power-mode controller
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, ctrl_wr, instr_done, irq_pending, wdog_reset, int_reset;
   logic osc_off_req, cpu_halt, periph_clk_en, osc_en, sys_clk_en, irq_wake;
   logic irq_timer_en, clk_detect_en, wdog_clk_en, core_reset;
   logic [7:0] ctrl_wdata, power_control_reg, d;
   logic [15:0] fetch_addr;
   logic [7:0] notes [$]; // Expected control byte per wake
   int n_mismatch = 0;
   int cmp_count = 0;
   pwm_power_modes pwm_power_modes_i(.clk, .rst_n, .ctrl_wr, .ctrl_wdata,
      .instr_done, .irq_pending, .wdog_reset, .int_reset, .osc_off_req,
      .power_control_reg, .cpu_halt, .periph_clk_en, .osc_en, .sys_clk_en,
      .irq_timer_en, .clk_detect_en, .wdog_clk_en, .irq_wake, .core_reset,
      .fetch_addr);
   pwm_core_model pwm_core_model_i(.clk, .ctrl_wr, .ctrl_wdata, .instr_done);
   initial
   begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic final_report();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report
   // Bounded wait until every note is used
   task automatic drain(input string s);
      repeat (10) if (notes.size() > 0) step(1);
      if (notes.size() > 0)
      begin
         n_mismatch++;
         final_report();
      end
      else
         $display("test %s done", s);
   endtask : drain
   // One-cycle reset request from watchdog or other source
   task automatic kick(input logic wd);
      {wdog_reset, int_reset} = {wd, !wd};
      notes.push_back(8'h00);
      step(1);
      {wdog_reset, int_reset} = 2'b00;
   endtask : kick
   // Compare each wake or reset against the oldest note
   always @(negedge clk)
      if (rst_n && (irq_wake === 1'b1 || core_reset === 1'b1))
         chk(power_control_reg, notes.size() > 0 ? notes.pop_front() : 8'hA5);
   initial
   begin
      {rst_n, irq_pending, wdog_reset, int_reset, osc_off_req} = 5'h00;
      void'($urandom(94));
      step(4);
      rst_n = 1;
      notes.push_back(8'h00);
      drain("reset");
      pwm_core_model_i.write(8'h01, 1'($urandom % 2));
      chk({cpu_halt, periph_clk_en, sys_clk_en}, 3'h7);
      step(1 + $urandom % 4);
      irq_pending = 1;
      notes.push_back(8'h00);
      step(1);
      irq_pending = 0;
      drain("idle wake");
      d = 8'h02 | 8'($urandom % 2);
      pwm_core_model_i.write(d, 1'b0);
      chk({cpu_halt, clk_detect_en}, 2'h3);
      chk({periph_clk_en, osc_en, sys_clk_en, irq_timer_en}, 4'h0);
      irq_pending = 1;
      step(3);
      chk(cpu_halt, 1'b1);
      irq_pending = 0;
      kick(1'b0);
      drain("stop");
      chk(fetch_addr, pwm_pkg::PWM_RESET_VECTOR);
      pwm_core_model_i.write(8'h01, 1'b0);
      step(5);
      chk(power_control_reg, 8'h01);
      chk({cpu_halt, wdog_clk_en}, 2'h3);
      kick(1'b1);
      drain("watchdog");
      chk(fetch_addr, pwm_pkg::PWM_RESET_VECTOR);
      osc_off_req = 1;
      step(1);
      {osc_off_req, irq_pending} = 2'b01;
      step(3);
      chk(cpu_halt, 1'b1);
      irq_pending = 0;
      kick(1'b0);
      drain("oscillator off");
      chk(cpu_halt, 1'b0);
      final_report();
   end
endmodule : tb_top
